// ---- include/agu_pkg.sv ----
// Package: constants and types for the data address generation unit
// Summary of operation
// [R1] Every access aligned to its own width
// [R2] Base must be multiple of access bytes
// [R3] Offsets and steps multiples of access size
// [R4] Final effective address aligned to width
// [R5] Misaligned generated address raises addressing fault
// [R6] Doubleword needs low three bits zero
// [R7] Bytes unrestricted; halfword even; doubleword by eight
// [R8] Step and scale derived from access width; code derives the step only, offset shift is fixed by mode at two or none
// [R9] Pipeline interlocked; no software hazard delays
// [R10] Packet holds two loads, one store
// [R11] Address register written once per packet
// [R12] Direct mode: 32-bit immediate, long instructions
// [R13] Pointer base from registers zero to fourteen
// [R14] Offset added with wrapping 32-bit addition
// [R15] Unscaled ten-bit offset covers one kilobyte
// [R16] Ten-bit offset shifted two covers 4KB
// [R17] Eight-bit shifted offset only for compact move
// [R18] Large 28-bit offset mode provided
// [R19] Large offset split: low twelve, high sixteen
// [R20] Faulted access performs no transfer, no write
package agu_pkg;
   localparam int ADDR_W = 32;
   localparam int NUM_AREG = 16;
   localparam logic [3:0] STACK_REG = 4'hF;
   localparam logic [3:0] MAX_PTR_REG = 4'hE;
   localparam int LO_OFS_W = 12;
   localparam int HI_OFS_W = 16;
   localparam int MED_OFS_W = 10;
   localparam int SMALL_OFS_W = 8;
   localparam logic [1:0] PERIPH_SHIFT = 2'h2;
   localparam int MAX_LOADS = 2;
   localparam int MAX_STORES = 1;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

   // Access width: encodes the step shift directly
   typedef enum logic [1:0]
   {
      WID_BYTE = 2'b00,
      WID_HALF = 2'b01,
      WID_WORD = 2'b10,
      WID_DBL = 2'b11
   } width_t;

   // Addressing modes handled here
   typedef enum logic [2:0]
   {
      MODE_DIRECT = 3'b000,
      MODE_LARGE = 3'b001,
      MODE_MED = 3'b010,
      MODE_MED_SHIFT = 3'b011,
      MODE_SMALL_SHIFT = 3'b100
   } mode_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_ISSUE = 2'b01,
      ST_FAULT = 2'b10
   } agu_state_t;

   // Mask of low address bits that must be zero for a width
   function automatic logic [2:0] align_mask(input width_t w);
      case (w)
         WID_BYTE: align_mask = 3'h0;
         WID_HALF: align_mask = 3'h1;
         WID_WORD: align_mask = 3'h3;
         default: align_mask = 3'h7;
      endcase
   endfunction

   // Byte step for a width
   function automatic logic [3:0] step_bytes(input width_t w);
      step_bytes = 4'h1 << w;
   endfunction
endpackage

// ---- include/agu_slot_if.sv ----
// Interface: one address slot between packet control and its checker
`timescale 1ns/10ps
interface agu_slot_if;
   import agu_pkg::*;
   logic valid;
   logic is_store;
   width_t width;
   mode_t mode;
   logic [3:0] base_reg;
   logic [31:0] base;
   logic [31:0] offset;
   logic [31:0] addr;
   logic fault;
   modport ctrl (output valid, is_store, width, mode, base_reg, base, offset,
      input addr, fault);
   modport calc (input valid, is_store, width, mode, base_reg, base, offset,
      output addr, fault);
endinterface

// ---- rtl/agu_slot.sv ----
// Module: effective address and alignment check for one access slot
`timescale 1ns/10ps
module agu_slot
   import agu_pkg::*;
(
   agu_slot_if.calc s // Slot request and result
);
   logic [31:0] scaled;
   logic [31:0] sum;
   logic base_bad;
   logic ofs_bad;
   logic mode_bad;

   // Offset scaling per mode; the shift is set by mode alone, not by access width
   always_comb
   begin
      case (s.mode)
         // Short fields are cut to their width so stray upper bits
         // on the operand bus cannot widen the reach
         MODE_MED: scaled = {22'h000000, s.offset[9:0]}; // see [R15]
         MODE_MED_SHIFT: // see [R16]
            scaled = {20'h00000, s.offset[9:0], 2'b00};
         MODE_SMALL_SHIFT: // see [R17]
            scaled = {22'h000000, s.offset[7:0], 2'b00};
         MODE_DIRECT: scaled = 32'h0000_0000; // see [R12]
         default: scaled = s.offset; // see [R18]
      endcase
   end

   // Wrapping 32-bit add; direct mode takes the immediate as address
   assign sum = (s.mode == MODE_DIRECT) ? s.offset
      : s.base + scaled; // see [R14]

   // Each part checked separately so a misaligned base or offset faults even if the sum aligns
   assign base_bad = (s.mode != MODE_DIRECT)
      && ((s.base[2:0] & align_mask(s.width)) != 3'h0); // see [R2]
   // Offset must be a whole number of width-derived steps
   assign ofs_bad = (scaled[3:0] & (step_bytes(s.width) - 4'h1))
      != 4'h0; // see [R3] [R7] [R8]
   assign mode_bad = (s.mode != MODE_DIRECT
      && s.base_reg > MAX_PTR_REG) // see [R13]
      || (s.mode == MODE_SMALL_SHIFT && s.width != WID_WORD); // see [R17]
   assign s.addr = sum;
   assign s.fault = s.valid && (base_bad || ofs_bad || mode_bad
      || ((sum[2:0] & align_mask(s.width)) != 3'h0)); // see [R4] [R6]
endmodule

// ---- rtl/agu_top.sv ----
// Module: packet-level data address generation with alignment faults
`timescale 1ns/10ps
module agu_top
   import agu_pkg::*;
(
   input wire logic CLK_I, // Core clock, 20 MHz
   input wire logic RESET_N_I, // Async reset, active low
   input wire logic PKT_VALID_I, // Packet presented
   output logic PKT_READY_O, // Unit can take a packet
   input wire logic [2:0] SLOT_VALID_I, // Slots 0,1 load, slot 2 store
   input wire logic [5:0] SLOT_WIDTH_I, // Two bits per slot, width_t
   input wire logic [8:0] SLOT_MODE_I, // Three bits per slot, mode_t
   input wire logic [11:0] SLOT_BREG_I, // Base register per slot
   input wire logic [95:0] SLOT_BASE_I, // Base value per slot
   input wire logic [95:0] SLOT_OFS_I, // Offset or direct immediate
   input wire logic [15:0] LARGE_HI_I, // Large offset upper 16 bits
   input wire logic [11:0] LARGE_LO_I, // Large offset lower 12 bits
   input wire logic [2:0] SLOT_WB_I, // Slot updates its base register
   input wire logic [2:0] SLOT_WREG_EXT_I, // Other writer hits same reg
   input wire logic MEM_READY_I, // Memory bus accepts transfers
   output logic [2:0] MEM_REQ_O, // Transfer request per slot
   output logic [95:0] MEM_ADDR_O, // Effective address per slot
   output logic [5:0] MEM_WIDTH_O, // Width per slot
   output logic [2:0] REG_WB_O, // Address register write enable
   output logic FAULT_O, // Addressing fault pulse
   output logic [2:0] FAULT_SLOT_O, // Which slots faulted
   output logic PKT_ERR_O // Packet rejected for conflicts
);
   typedef struct packed {
      agu_state_t st;
      logic [2:0] req;
      logic [95:0] addr;
      logic [5:0] width;
      logic [2:0] wb;
      logic fault;
      logic [2:0] fslot;
      logic perr;
      logic rdy; // Registered so ready comes straight from a flop
   } agu_regs_t;

   agu_regs_t r;
   agu_regs_t next_r;
   logic [2:0] flt;
   logic [95:0] addr_c;
   logic conflict;
   logic [31:0] large_ofs;

   // Large offset reassembled from its two instruction fields
   assign large_ofs = {4'h0, LARGE_HI_I, LARGE_LO_I}; // see [R19] [R18]

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_slot
         agu_slot_if sif();
         assign sif.valid = SLOT_VALID_I[g];
         assign sif.is_store = (g == 2);
         assign sif.width = width_t'(SLOT_WIDTH_I[2*g +: 2]); // see [R8]
         assign sif.mode = mode_t'(SLOT_MODE_I[3*g +: 3]);
         assign sif.base_reg = SLOT_BREG_I[4*g +: 4];
         assign sif.base = SLOT_BASE_I[32*g +: 32];
         assign sif.offset = (sif.mode == MODE_LARGE) ? large_ofs
            : SLOT_OFS_I[32*g +: 32];
         assign addr_c[32*g +: 32] = sif.addr;
         assign flt[g] = sif.fault; // see [R5] [R1]
         agu_slot u_slot (.s(sif.calc));
      end
   endgenerate

   // Two writers to one address register in a packet is illegal
   always_comb
   begin
      conflict = |(SLOT_WB_I & SLOT_VALID_I & SLOT_WREG_EXT_I); // see [R11]
      for (int i = 0; i < 3; i++)
      begin
         for (int j = i + 1; j < 3; j++)
         begin
            // Idle slots carry stale fields; only live writers count
            if (SLOT_VALID_I[i] && SLOT_VALID_I[j]
               && SLOT_WB_I[i] && SLOT_WB_I[j]
               && SLOT_BREG_I[4*i +: 4] == SLOT_BREG_I[4*j +: 4])
            begin
               conflict = 1'b1;
            end
         end
      end
   end

   // Next state: packet held until memory accepts, which is the interlock
   always_comb
   begin
      next_r = r;
      next_r.fault = 1'b0;
      next_r.perr = 1'b0;
      case (r.st)
         ST_IDLE:
         begin
            next_r.req = 3'b000;
            next_r.wb = 3'b000;
            if (PKT_VALID_I)
            begin
               // Fixed slot set limits a packet to two loads, one store
               next_r.addr = addr_c; // see [R10]
               next_r.width = SLOT_WIDTH_I;
               next_r.fslot = flt;
               if (conflict)
               begin
                  next_r.perr = 1'b1;
                  next_r.st = ST_FAULT;
               end
               else if (|flt)
               begin
                  // Faulted packet: nothing goes to memory or registers
                  next_r.fault = 1'b1; // see [R5] [R20]
                  next_r.st = ST_FAULT;
               end
               else
               begin
                  next_r.req = SLOT_VALID_I;
                  next_r.wb = SLOT_VALID_I & SLOT_WB_I;
                  next_r.st = ST_ISSUE;
               end
            end
         end
         ST_ISSUE:
         begin
            // Stall here while memory is busy, see [R9]
            if (MEM_READY_I)
            begin
               next_r.req = 3'b000;
               next_r.wb = 3'b000;
               next_r.st = ST_IDLE;
            end
         end
         ST_FAULT:
         begin
            next_r.req = 3'b000;
            next_r.wb = 3'b000;
            next_r.st = ST_IDLE;
         end
         default:
         begin
            next_r.st = ST_IDLE;
         end
      endcase
      // Ready follows the state that is about to be entered
      next_r.rdy = (next_r.st == ST_IDLE);
   end

   // State register
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         r <= '{st: ST_IDLE, req: 3'h0, addr: {3{ADDR_RESET}}, width: 6'h00,
            wb: 3'h0, fault: 1'b0, fslot: 3'h0, perr: 1'b0, rdy: 1'b1};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign PKT_READY_O = r.rdy;
   assign MEM_REQ_O = r.req;
   assign MEM_ADDR_O = r.addr;
   assign MEM_WIDTH_O = r.width;
   assign REG_WB_O = r.wb;
   assign FAULT_O = r.fault;
   assign FAULT_SLOT_O = r.fslot;
   assign PKT_ERR_O = r.perr;

   // Checks: a faulted packet must never reach memory or registers
   chk_fault_blocks: assert property ( // see [R20]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      r.fault |-> (r.req == 3'h0 && r.wb == 3'h0))
      else $error("faulted packet issued a transfer");
   chk_fault_cause: assert property ( // see [R5]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (r.st == ST_IDLE && PKT_VALID_I && !conflict && |flt) |=> FAULT_O)
      else $error("misaligned access raised no fault");
   chk_dbl_align: assert property ( // see [R6]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (r.st == ST_IDLE && PKT_VALID_I && SLOT_VALID_I[0]
      && SLOT_WIDTH_I[1:0] == 2'b11 && addr_c[2:0] != 3'h0) |-> flt[0])
      else $error("doubleword misalign missed");
   chk_issue_aligned: assert property ( // see [R4]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (MEM_REQ_O[2] && MEM_WIDTH_O[5:4] == 2'b10)
      |-> MEM_ADDR_O[65:64] == 2'h0)
      else $error("store issued misaligned");
   chk_hold_stall: assert property ( // see [R9]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (r.st == ST_ISSUE && !MEM_READY_I)
      |=> $stable(MEM_ADDR_O) && !PKT_READY_O)
      else $error("request dropped during stall");
   chk_single_write: assert property ( // see [R11]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (r.st == ST_IDLE && PKT_VALID_I && conflict)
      |=> PKT_ERR_O && REG_WB_O == 3'h0)
      else $error("double register write accepted");
   chk_wrap_add: assert property ( // see [R14] [R15]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (SLOT_MODE_I[2:0] == 3'b010) |-> addr_c[31:0]
      == SLOT_BASE_I[31:0] + {22'h000000, SLOT_OFS_I[9:0]})
      else $error("offset sum wrong");
   chk_byte_free: assert property ( // see [R7]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (SLOT_VALID_I[1] && SLOT_WIDTH_I[3:2] == 2'b00
      && SLOT_MODE_I[5:3] == 3'b000) |-> !flt[1])
      else $error("byte access faulted");
   // The stack pointer may never serve as a pointer base
   chk_stack_base: assert property ( // see [R13]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (SLOT_VALID_I[0] && SLOT_MODE_I[2:0] != 3'b000
      && SLOT_BREG_I[3:0] == STACK_REG) |-> flt[0])
      else $error("stack register accepted as base");
   chk_large_sum: assert property ( // see [R19]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (SLOT_MODE_I[2:0] == 3'b001)
      |-> addr_c[31:0] == SLOT_BASE_I[31:0] + large_ofs)
      else $error("large offset sum wrong");
   // A fault costs one cycle; the unit must come back for the next packet
   chk_fault_ready: assert property ( // see [R9]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (r.st == ST_FAULT) |=> PKT_READY_O)
      else $error("unit stuck after fault");
   chk_wb_with_req: assert property ( // see [R20]
      @(posedge CLK_I) disable iff (!RESET_N_I)
      (REG_WB_O != 3'h0) |-> (MEM_REQ_O & REG_WB_O) == REG_WB_O)
      else $error("register write without transfer");
   cov_issue: cover property (@(posedge CLK_I) r.st == ST_ISSUE && MEM_READY_I);
   cov_fault: cover property (@(posedge CLK_I) FAULT_O);
   cov_full: cover property (@(posedge CLK_I) MEM_REQ_O == 3'b111);
   cov_conflict: cover property (@(posedge CLK_I) PKT_ERR_O);
   cov_stall: cover property (@(posedge CLK_I)
      r.st == ST_ISSUE && !MEM_READY_I);
endmodule

// ---- sim/mem_model.sv ----
// Memory bus partner: stalls by a set lag and flags misaligned transfers
`timescale 1ns/10ps
module mem_model
(
   input wire logic clk_i, // Core clock
   input wire logic reset_n_i, // Async reset, active low
   input wire logic [2:0] req_i, // Transfer request per slot
   input wire logic [95:0] addr_i, // Address per slot
   input wire logic [5:0] width_i, // Width per slot
   input wire logic [3:0] lag_i, // Stall cycles before accepting
   output logic ready_o, // Accepts pending transfers
   output logic bad_o // Sticky: misaligned transfer seen
);
   logic [3:0] wait_cnt;
   // Ready only while a request is up, so a stale grant cannot leak
   assign ready_o = (req_i != 3'h0) && (wait_cnt >= lag_i);
   // Stall counter; any misaligned accepted transfer is remembered
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wait_cnt <= 4'h0;
         bad_o <= 1'b0;
      end
      else
      begin
         wait_cnt <= (req_i == 3'h0 || ready_o) ? 4'h0 : wait_cnt + 4'h1;
         for (int g = 0; g < 3; g++)
         begin
            if (ready_o && req_i[g] && (addr_i[32*g+:3] &
               ((3'h1 << width_i[2*g+:2]) - 3'h1)) != 3'h0)
               bad_o <= 1'b1;
         end
      end
   end
endmodule

// ---- sim/tb_top.sv ----
// Testbench: packet address generation, alignment faults, conflicts
`timescale 1ns/10ps
module tb_top;
   import agu_pkg::*;
   logic CLK_I = 1'b0;
   logic RESET_N_I = 1'b0;
   logic PKT_VALID_I = 1'b0;
   logic [2:0] SLOT_VALID_I = 3'h0;
   logic [5:0] SLOT_WIDTH_I = 6'h0;
   logic [8:0] SLOT_MODE_I = 9'h0;
   logic [11:0] SLOT_BREG_I = 12'h0;
   logic [95:0] SLOT_BASE_I = 96'h0;
   logic [95:0] SLOT_OFS_I = 96'h0;
   logic [15:0] LARGE_HI_I = 16'h0;
   logic [11:0] LARGE_LO_I = 12'h0;
   logic [2:0] SLOT_WB_I = 3'h0;
   logic [2:0] SLOT_WREG_EXT_I = 3'h0;
   logic MEM_READY_I;
   logic PKT_READY_O, FAULT_O, PKT_ERR_O, mem_bad;
   logic [2:0] MEM_REQ_O, REG_WB_O, FAULT_SLOT_O;
   logic [95:0] MEM_ADDR_O;
   logic [5:0] MEM_WIDTH_O;
   logic [3:0] lag = 4'h0;
   logic [31:0] exp_addr [3];
   int n_errors = 0;
   int checks_done = 0;

   agu_top dut_u (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
      .PKT_VALID_I(PKT_VALID_I), .PKT_READY_O(PKT_READY_O),
      .SLOT_VALID_I(SLOT_VALID_I), .SLOT_WIDTH_I(SLOT_WIDTH_I),
      .SLOT_MODE_I(SLOT_MODE_I), .SLOT_BREG_I(SLOT_BREG_I),
      .SLOT_BASE_I(SLOT_BASE_I), .SLOT_OFS_I(SLOT_OFS_I),
      .LARGE_HI_I(LARGE_HI_I), .LARGE_LO_I(LARGE_LO_I),
      .SLOT_WB_I(SLOT_WB_I), .SLOT_WREG_EXT_I(SLOT_WREG_EXT_I),
      .MEM_READY_I(MEM_READY_I), .MEM_REQ_O(MEM_REQ_O),
      .MEM_ADDR_O(MEM_ADDR_O), .MEM_WIDTH_O(MEM_WIDTH_O),
      .REG_WB_O(REG_WB_O), .FAULT_O(FAULT_O),
      .FAULT_SLOT_O(FAULT_SLOT_O), .PKT_ERR_O(PKT_ERR_O));
   mem_model mem_u (.clk_i(CLK_I), .reset_n_i(RESET_N_I), .req_i(MEM_REQ_O),
      .addr_i(MEM_ADDR_O), .width_i(MEM_WIDTH_O), .lag_i(lag),
      .ready_o(MEM_READY_I), .bad_o(mem_bad));

   // Free-running core clock, 50 ns period
   always #25 CLK_I = ~CLK_I;

   // Expected address from mode; 32-bit sum wraps on purpose
   function automatic logic [31:0] ea(input logic [2:0] m,
      input logic [31:0] b, input logic [31:0] o);
      case (m)
         3'h0: ea = o;
         3'h1: ea = b + {4'h0, LARGE_HI_I, LARGE_LO_I};
         3'h2: ea = b + {22'h000000, o[9:0]};
         3'h3: ea = b + {20'h00000, o[9:0], 2'b00};
         default: ea = b + {22'h000000, o[7:0], 2'b00};
      endcase
   endfunction

   task automatic ck(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic slot(input int g, input width_t w, input mode_t m,
      input logic [3:0] r, input logic [31:0] b, input logic [31:0] o);
      SLOT_VALID_I[g] = 1'b1;
      SLOT_WIDTH_I[2*g+:2] = w;
      SLOT_MODE_I[3*g+:3] = m;
      SLOT_BREG_I[4*g+:4] = r;
      SLOT_BASE_I[32*g+:32] = b;
      SLOT_OFS_I[32*g+:32] = o;
      exp_addr[g] = ea(m, b, o);
   endtask

   // Offer the packet, judge the answer, wait out the transfer
   task automatic judge(input logic [2:0] ereq, input logic [2:0] efs,
      input logic eerr, input logic [2:0] ewb);
      int i;
      while (PKT_READY_O !== 1'b1)
      begin
         @(posedge CLK_I);
         #1;
      end
      PKT_VALID_I = 1'b1;
      @(posedge CLK_I);
      #1;
      PKT_VALID_I = 1'b0;
      for (i = 0; i < 6 && MEM_REQ_O == 3'h0 && FAULT_O !== 1'b1 &&
         PKT_ERR_O !== 1'b1; i++)
      begin
         @(posedge CLK_I);
         #1;
      end
      ck(MEM_REQ_O === ereq, "request set");
      ck(FAULT_O === (efs != 3'h0), "fault pulse");
      ck(FAULT_SLOT_O === efs || eerr, "fault slots");
      ck(PKT_ERR_O === eerr, "conflict flag");
      ck(REG_WB_O === ewb, "register write");
      for (int g = 0; g < 3; g++)
      begin
         if (ereq[g])
         begin
            ck(MEM_ADDR_O[32*g+:32] === exp_addr[g], "address");
            ck(MEM_WIDTH_O[2*g+:2] === SLOT_WIDTH_I[2*g+:2],
               "width");
         end
      end
      if (ereq != 3'h0)
         ck(PKT_READY_O === 1'b0, "busy while issuing");
      if (ereq != 3'h0 && lag > 4'h0)
      begin
         @(posedge CLK_I);
         #1;
         ck(MEM_REQ_O === ereq, "request held in stall");
      end
      for (i = 0; i < 20 && MEM_REQ_O != 3'h0; i++)
      begin
         @(posedge CLK_I);
         #1;
      end
      ck(MEM_REQ_O === 3'h0 && mem_bad === 1'b0,
         "clean release");
      SLOT_VALID_I = 3'h0;
      SLOT_WB_I = 3'h0;
      SLOT_WREG_EXT_I = 3'h0;
      // Let an edge pass so the next packet's fields start in a new step
      @(posedge CLK_I);
      #1;
   endtask

   task automatic t_issue();
      lag = 4'h3;
      slot(0, WID_DBL, MODE_DIRECT, 4'h0, 32'h0, 32'hF8);
      slot(1, WID_WORD, MODE_MED, 4'h1, 32'h100, 32'h3FC);
      slot(2, WID_WORD, MODE_MED_SHIFT, 4'h2, 32'h1000, 32'h3FF);
      SLOT_WB_I = 3'h4;
      judge(3'h7, 3'h0, 1'b0, 3'h4);
      lag = 4'h0;
      slot(0, WID_WORD, MODE_SMALL_SHIFT, 4'h3, 32'h40, 32'hFF);
      judge(3'h1, 3'h0, 1'b0, 3'h0);
      $display("issue test done");
   endtask

   task automatic t_large();
      LARGE_HI_I = 16'h0001;
      LARGE_LO_I = 12'h008;
      slot(0, WID_DBL, MODE_LARGE, 4'hE, 32'hFFFF_FFF8, 32'h0);
      slot(1, WID_WORD, MODE_LARGE, 4'h0, 32'h0, 32'h0);
      judge(3'h3, 3'h0, 1'b0, 3'h0);
      $display("large offset test done");
   endtask

   task automatic t_faults();
      slot(0, WID_DBL, MODE_DIRECT, 4'h0, 32'h0, 32'hF9);
      judge(3'h0, 3'h1, 1'b0, 3'h0);
      slot(0, WID_HALF, MODE_MED, 4'h1, 32'h100, 32'h5);
      judge(3'h0, 3'h1, 1'b0, 3'h0);
      slot(0, WID_WORD, MODE_MED, 4'h1, 32'h102, 32'h2);
      judge(3'h0, 3'h1, 1'b0, 3'h0);
      // Odd byte addresses pass; the store's medium offset is cut to 10 bits
      slot(0, WID_BYTE, MODE_MED, 4'h1, 32'h101, 32'h9);
      slot(1, WID_BYTE, MODE_DIRECT, 4'h0, 32'h0, 32'h203);
      slot(2, WID_WORD, MODE_MED, 4'h4, 32'h200, 32'h404);
      judge(3'h7, 3'h0, 1'b0, 3'h0);
      slot(0, WID_DBL, MODE_MED_SHIFT, 4'h1, 32'h100, 32'h1);
      judge(3'h0, 3'h1, 1'b0, 3'h0);
      slot(0, WID_DBL, MODE_MED_SHIFT, 4'h1, 32'h100, 32'h2);
      judge(3'h1, 3'h0, 1'b0, 3'h0);
      slot(0, WID_WORD, MODE_MED, 4'hF, 32'h100, 32'h0);
      judge(3'h0, 3'h1, 1'b0, 3'h0);
      slot(0, WID_HALF, MODE_SMALL_SHIFT, 4'h1, 32'h100, 32'h1);
      judge(3'h0, 3'h1, 1'b0, 3'h0);
      slot(0, WID_WORD, MODE_MED, 4'h1, 32'h100, 32'h4);
      slot(1, WID_DBL, MODE_DIRECT, 4'h0, 32'h0, 32'h104);
      SLOT_WB_I = 3'h1;
      judge(3'h0, 3'h2, 1'b0, 3'h0);
      $display("fault test done");
   endtask

   task automatic t_conflict();
      slot(0, WID_WORD, MODE_MED, 4'h1, 32'h100, 32'h4);
      slot(1, WID_DBL, MODE_DIRECT, 4'h0, 32'h0, 32'h4);
      SLOT_WB_I = 3'h1;
      SLOT_WREG_EXT_I = 3'h1;
      judge(3'h0, 3'h0, 1'b1, 3'h0);
      $display("conflict test done");
   endtask

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Main sequence: reset for 20 cycles, then each scenario in turn
   initial
   begin
      repeat (20) @(posedge CLK_I);
      #1;
      RESET_N_I = 1'b1;
      t_issue();
      t_large();
      t_faults();
      t_conflict();
      close_out();
   end

   // Watchdog: run needs under a hundred cycles, allow 3000 cycles
   initial
   begin
      #(3000 * 50);
      n_errors++;
      close_out();
   end
endmodule
